//--- inc/fault_resp_pkg.sv
// Behaviour
// - An output overcurrent fault sets the overcurrent bit of the output-current status register and triggers the configured shutdown.
// - An output undercurrent fault sets the undercurrent status bit and follows the separate undercurrent action setting.
// - In every response mode the active-low alert output is pulled low and the related status bit is set.
// - Fault status bits stay set until a CLEAR_FAULTS command and nothing else clears them.
// - Response field 10 in bits 7:6 disables the output at once and then follows the retry field; 00, 01 and 11 are unused.
// - Retry field 000 keeps the output off after the fault until the fault is cleared; codes 001 to 110 are unused.
// - Retry field 111 restarts repeatedly without rechecking the fault until switched off by pin or operation command or shut down by another fault.
// - The spacing between restart attempts is (retry delay field + 1) times 35 ms, 35 ms to 280 ms.
// - The spacing is measured from the start of one restart attempt to the start of the next.
// - After reset each fault action setting holds 80h, immediate shutdown with no restarts.
package fault_resp_pkg;

  // ----------------------------------------------------------------
  // command codes and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_OC_ACTION = 8'hE5;
  localparam logic [7:0] CMD_UC_ACTION = 8'hE6;
  localparam logic [7:0] CMD_STATUS_IOUT = 8'h7B;
  localparam logic [7:0] ACTION_RESET = 8'h80;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int unsigned RESP_MSB = 7;
  localparam int unsigned RESP_LSB = 6;
  localparam int unsigned RETRY_MSB = 5;
  localparam int unsigned RETRY_LSB = 3;
  localparam int unsigned DELAY_MSB = 2;
  localparam int unsigned DELAY_LSB = 0;
  localparam logic [1:0] RESP_SHUTDOWN = 2'b10;
  localparam logic [2:0] RETRY_NONE = 3'b000;
  localparam logic [2:0] RETRY_FOREVER = 3'b111;
  localparam int unsigned STAT_OC_BIT = 7;
  localparam int unsigned STAT_UC_BIT = 4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned RETRY_UNIT_MS = 35;
  localparam int unsigned RETRY_TICK_CYCLES_DFLT =
    (RETRY_UNIT_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned PRESCALE_W = 22;
  localparam logic [3:0] TICK_ONE = 4'h1;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_ON = 2'b01,
    ST_LATCHED = 2'b10,
    ST_RETRY = 2'b11
  } run_state_t;

  // shutdown with endless restart is the only mode that retries
  function automatic logic retries_forever(input logic [7:0] action);
    retries_forever = (action[RESP_MSB:RESP_LSB] == RESP_SHUTDOWN) &&
                      (action[RETRY_MSB:RETRY_LSB] == RETRY_FOREVER);
  endfunction : retries_forever

endpackage : fault_resp_pkg

//--- design/retry_timer.sv
`timescale 1ns/100ps
`default_nettype none
module retry_timer #(
  parameter int unsigned TICK_CYCLES = fault_resp_pkg::RETRY_TICK_CYCLES_DFLT
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // control
  input wire logic start_i,
  input wire logic [2:0] delay_i,
  // result
  output logic expired_o
);

  logic [fault_resp_pkg::PRESCALE_W-1:0] pre_q;
  logic [3:0] ticks_q;
  logic [3:0] target_q;
  logic running_q;
  logic tick;

  // ----------------------------------------------------------------
  // prescaler: one tick per retry unit
  // ----------------------------------------------------------------
  assign tick = running_q &&
    (pre_q == fault_resp_pkg::PRESCALE_W'(TICK_CYCLES - 1));

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pre_q <= '0;
    end else if (start_i || tick) begin
      pre_q <= '0;
    end else if (running_q) begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // unit counter, restarted by every attempt
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ticks_q <= '0;
      target_q <= fault_resp_pkg::TICK_ONE;
      running_q <= 1'b0;
    end else begin
      if (start_i) begin
        ticks_q <= '0;
        target_q <= {1'b0, delay_i} + fault_resp_pkg::TICK_ONE;
        running_q <= 1'b1;
      end else if (tick) begin
        ticks_q <= ticks_q + 1'b1;
        if (ticks_q + 1'b1 == target_q) begin
          running_q <= 1'b0;
        end
      end
    end
  end

  // combinational, so the next attempt lands exactly one interval on
  assign expired_o = tick && (ticks_q + 1'b1 == target_q);

endmodule : retry_timer
`default_nettype wire

//--- design/output_current_fault_response.sv
`timescale 1ns/100ps
`default_nettype none
module output_current_fault_response #(
  parameter int unsigned RETRY_TICK_CYCLES =
    fault_resp_pkg::RETRY_TICK_CYCLES_DFLT
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // decoded command port
  input wire logic [7:0] cmd_code_i,
  input wire logic wr_en_i,
  input wire logic [7:0] wr_data_i,
  input wire logic rd_en_i,
  output logic [7:0] rd_data_o,
  input wire logic clear_faults_i,
  // fault detectors and run control
  input wire logic oc_fault_i,
  input wire logic uc_fault_i,
  input wire logic other_fault_i,
  input wire logic ctrl_pin_i,
  input wire logic operation_on_i,
  // output stage and alert
  output logic output_enable_o,
  output logic restart_o,
  output logic alert_out_n_o
);

  logic ctrl_meta_q;
  logic ctrl_sync_q;
  logic [7:0] oc_action_q;
  logic [7:0] uc_action_q;
  logic status_oc_q;
  logic status_uc_q;
  fault_resp_pkg::run_state_t state_q;
  fault_resp_pkg::run_state_t state_d;
  logic retrying_q;
  logic [2:0] retry_delay_q;
  logic run_cmd;
  logic fault_hit;
  logic [7:0] sel_action;
  logic wants_retry;
  logic attempt;
  logic timer_start;
  logic timer_exp;

  // ----------------------------------------------------------------
  // control pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_meta_q <= 1'b0;
      ctrl_sync_q <= 1'b0;
    end else begin
      ctrl_meta_q <= ctrl_pin_i;
      ctrl_sync_q <= ctrl_meta_q;
    end
  end

  assign run_cmd = ctrl_sync_q && operation_on_i;

  // ----------------------------------------------------------------
  // action settings
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      oc_action_q <= fault_resp_pkg::ACTION_RESET;
      uc_action_q <= fault_resp_pkg::ACTION_RESET;
    end else if (wr_en_i) begin
      if (cmd_code_i == fault_resp_pkg::CMD_OC_ACTION) begin
        oc_action_q <= wr_data_i;
      end
      if (cmd_code_i == fault_resp_pkg::CMD_UC_ACTION) begin
        uc_action_q <= wr_data_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // read-back, registered
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_o <= fault_resp_pkg::READ_UNMAPPED;
    end else if (rd_en_i) begin
      unique case (cmd_code_i)
        fault_resp_pkg::CMD_OC_ACTION: begin
          rd_data_o <= oc_action_q;
        end
        fault_resp_pkg::CMD_UC_ACTION: begin
          rd_data_o <= uc_action_q;
        end
        fault_resp_pkg::CMD_STATUS_IOUT: begin
          rd_data_o <= fault_resp_pkg::READ_UNMAPPED;
          rd_data_o[fault_resp_pkg::STAT_OC_BIT] <= status_oc_q;
          rd_data_o[fault_resp_pkg::STAT_UC_BIT] <= status_uc_q;
        end
        default: begin
          rd_data_o <= fault_resp_pkg::READ_UNMAPPED;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sticky status; a new fault beats a same-cycle clear
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_oc_q <= 1'b0;
    end else if (oc_fault_i) begin
      status_oc_q <= 1'b1;
    end else if (clear_faults_i) begin
      status_oc_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_uc_q <= 1'b0;
    end else if (uc_fault_i) begin
      status_uc_q <= 1'b1;
    end else if (clear_faults_i) begin
      status_uc_q <= 1'b0;
    end
  end

  assign alert_out_n_o = !(status_oc_q || status_uc_q);

  // ----------------------------------------------------------------
  // response selection
  // ----------------------------------------------------------------
  // overcurrent wins when both strike together
  assign fault_hit = (state_q == fault_resp_pkg::ST_ON) &&
                     (oc_fault_i || uc_fault_i);
  assign sel_action = oc_fault_i ? oc_action_q : uc_action_q;
  // unused codes fall back to latch-off, the safe reading
  assign wants_retry = fault_resp_pkg::retries_forever(sel_action);
  assign attempt = (state_q == fault_resp_pkg::ST_RETRY) && timer_exp &&
                   run_cmd && !other_fault_i;
  // a repeat fault during an attempt keeps the running interval
  // a fault right as the interval ends opens a fresh episode, not a hang
  assign timer_start = attempt ||
                       (fault_hit && wants_retry && !other_fault_i &&
                        (!retrying_q || timer_exp));

  // ----------------------------------------------------------------
  // run state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      fault_resp_pkg::ST_OFF: begin
        if (run_cmd) begin
          state_d = fault_resp_pkg::ST_ON;
        end
      end
      fault_resp_pkg::ST_ON: begin
        if (other_fault_i) begin
          state_d = fault_resp_pkg::ST_LATCHED;
        end else if (fault_hit) begin
          state_d = wants_retry ? fault_resp_pkg::ST_RETRY
                                : fault_resp_pkg::ST_LATCHED;
        end else if (!run_cmd) begin
          state_d = fault_resp_pkg::ST_OFF;
        end
      end
      fault_resp_pkg::ST_LATCHED: begin
        if (clear_faults_i) begin
          state_d = fault_resp_pkg::ST_OFF;
        end
      end
      fault_resp_pkg::ST_RETRY: begin
        if (other_fault_i) begin
          state_d = fault_resp_pkg::ST_LATCHED;
        end else if (!run_cmd) begin
          state_d = fault_resp_pkg::ST_OFF;
        end else if (attempt) begin
          state_d = fault_resp_pkg::ST_ON;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= fault_resp_pkg::ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // interval ends on its own once an attempt outlives it
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      retrying_q <= 1'b0;
      retry_delay_q <= '0;
    end else if (fault_hit && wants_retry && !other_fault_i) begin
      retrying_q <= 1'b1;
      if (!retrying_q || timer_exp) begin
        retry_delay_q <= sel_action[fault_resp_pkg::DELAY_MSB:
                                    fault_resp_pkg::DELAY_LSB];
      end
    end else if (state_d == fault_resp_pkg::ST_OFF ||
                 state_d == fault_resp_pkg::ST_LATCHED ||
                 (state_q == fault_resp_pkg::ST_ON && timer_exp)) begin
      retrying_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      restart_o <= 1'b0;
    end else begin
      restart_o <= attempt;
    end
  end

  assign output_enable_o = (state_q == fault_resp_pkg::ST_ON);

  retry_timer #(
    .TICK_CYCLES(RETRY_TICK_CYCLES)
  ) u_retry_timer (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .start_i(timer_start),
    .delay_i(fault_hit ? sel_action[2:0] : retry_delay_q),
    .expired_o(timer_exp)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  int unsigned elapsed_q;
  logic first_q;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      elapsed_q <= 0;
      first_q <= 1'b1;
    end else begin
      elapsed_q <= timer_start ? 0 : elapsed_q + 1;
      first_q <= 1'b0;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_oc_sets;
    oc_fault_i |=> status_oc_q;
  endproperty
  a_oc_sets: assert property (p_oc_sets)
    else $error("overcurrent did not set status");
  property p_uc_sets;
    uc_fault_i |=> status_uc_q ##0 !alert_out_n_o;
  endproperty
  a_uc_sets: assert property (p_uc_sets)
    else $error("undercurrent did not set status");
  // a clear in the cycle after the fault may legally lift the alert
  property p_alert;
    (oc_fault_i || uc_fault_i) ##1 !clear_faults_i
      |-> !alert_out_n_o ##1 !alert_out_n_o;
  endproperty
  a_alert: assert property (p_alert)
    else $error("alert not held low after fault");
  property p_sticky;
    (status_oc_q && !clear_faults_i) |=> status_oc_q;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("status cleared without command");
  property p_shutdown;
    fault_hit && !other_fault_i |=> !output_enable_o;
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("output not disabled on fault");
  property p_latched;
    (state_q == fault_resp_pkg::ST_LATCHED && !clear_faults_i)
      |=> state_q == fault_resp_pkg::ST_LATCHED && !output_enable_o;
  endproperty
  a_latched: assert property (p_latched)
    else $error("latched output restarted");
  property p_retry_entry;
    (fault_hit && wants_retry && !other_fault_i)
      |=> state_q == fault_resp_pkg::ST_RETRY;
  endproperty
  a_retry_entry: assert property (p_retry_entry)
    else $error("retry mode not entered");
  // expiry shows in the last cycle of the interval
  property p_interval;
    timer_exp |->
      elapsed_q + 1 == (retry_delay_q + 1) * RETRY_TICK_CYCLES;
  endproperty
  a_interval: assert property (p_interval)
    else $error("retry interval wrong");
  property p_attempt_restarts;
    attempt |-> timer_start ##1 output_enable_o && restart_o;
  endproperty
  a_attempt_restarts: assert property (p_attempt_restarts)
    else $error("attempt did not restart interval");
  property p_reset_value;
    first_q |-> oc_action_q == fault_resp_pkg::ACTION_RESET &&
                uc_action_q == fault_resp_pkg::ACTION_RESET;
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("action reset value wrong");
  property p_prescale;
    timer_start |=> !timer_exp;
  endproperty
  a_prescale: assert property (p_prescale)
    else $error("timer expired at start");

  c_attempt: cover property (attempt);
  c_latch: cover property (state_q == fault_resp_pkg::ST_LATCHED
                           ##1 clear_faults_i);
  c_refault: cover property (fault_hit && retrying_q);

endmodule : output_current_fault_response
`default_nettype wire

//--- test/host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // clock
  input wire logic clk_i,
  // command port
  output logic [7:0] cmd_code_o,
  output logic wr_en_o,
  output logic [7:0] wr_data_o,
  output logic rd_en_o,
  input wire logic [7:0] rd_data_i,
  output logic clear_o
);
  initial begin
    cmd_code_o = 8'h00;
    wr_en_o = 1'b0;
    wr_data_o = 8'h00;
    rd_en_o = 1'b0;
    clear_o = 1'b0;
  end

  // idle bus toggles so stale codes are never mistaken for requests
  task automatic release_bus();
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    clear_o = 1'b0;
    cmd_code_o = ~cmd_code_o;
    wr_data_o = ~wr_data_o;
  endtask : release_bus

  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    cmd_code_o = c;
    wr_data_o = d;
    wr_en_o = 1'b1;
    @(posedge clk_i);
    #1;
    release_bus();
  endtask : wr

  task automatic rd(input logic [7:0] c, output logic [7:0] q);
    @(posedge clk_i);
    #1;
    cmd_code_o = c;
    rd_en_o = 1'b1;
    @(posedge clk_i);
    #1;
    q = rd_data_i;
    release_bus();
  endtask : rd

  task automatic clr();
    @(posedge clk_i);
    #1;
    clear_o = 1'b1;
    @(posedge clk_i);
    #1;
    release_bus();
  endtask : clr
endmodule : host_model
`default_nettype wire

//--- test/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int unsigned TICK = 4;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] cmd_code;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic wr_en;
  logic rd_en;
  logic clr;
  logic oc_fault = 1'b0;
  logic uc_fault = 1'b0;
  logic other_fault = 1'b0;
  logic ctrl_pin = 1'b0;
  logic operation_on = 1'b0;
  logic out_en;
  logic restart;
  logic alert_n;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [7:0] q;
  logic [7:0] g;
  logic [2:0] d;
  int n;

  always #5 core_clk = ~core_clk;

  host_model host_model_i (.clk_i(core_clk), .cmd_code_o(cmd_code),
    .wr_en_o(wr_en), .wr_data_o(wr_data), .rd_en_o(rd_en),
    .rd_data_i(rd_data), .clear_o(clr));

  output_current_fault_response #(.RETRY_TICK_CYCLES(TICK))
    output_current_fault_response_i (.core_clk_i(core_clk),
    .rst_b_i(rst_b), .cmd_code_i(cmd_code), .wr_en_i(wr_en),
    .wr_data_i(wr_data), .rd_en_i(rd_en), .rd_data_o(rd_data),
    .clear_faults_i(clr), .oc_fault_i(oc_fault), .uc_fault_i(uc_fault),
    .other_fault_i(other_fault), .ctrl_pin_i(ctrl_pin),
    .operation_on_i(operation_on), .output_enable_o(out_en),
    .restart_o(restart), .alert_out_n_o(alert_n));

  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] stat(input logic oc, input logic uc);
    stat = 8'h00;
    stat[fault_resp_pkg::STAT_OC_BIT] = oc;
    stat[fault_resp_pkg::STAT_UC_BIT] = uc;
  endfunction : stat

  function automatic logic [7:0] gap(input logic [2:0] dl);
    gap = 8'(({5'h00, dl} + 8'h01) * TICK);
  endfunction : gap

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  // counts cycles up to the next restart pulse, or lim if none comes
  task automatic wait_restart(input int lim, output int cnt);
    cnt = 0;
    while (cnt < lim) begin
      @(posedge core_clk);
      #1;
      cnt++;
      if (restart === 1'b1) begin
        break;
      end
    end
  endtask : wait_restart

  task automatic expect_on();
    repeat (10) begin
      if (out_en !== 1'b1) begin
        @(posedge core_clk);
        #1;
      end
    end
    chk({7'h00, out_en}, 8'h01);
  endtask : expect_on

  task automatic hit(input logic oc, input logic uc);
    @(posedge core_clk);
    #1;
    oc_fault = oc;
    uc_fault = uc;
    @(posedge core_clk);
    #1;
    oc_fault = 1'b0;
    uc_fault = 1'b0;
    chk({7'h00, out_en}, 8'h00);
    chk({7'h00, alert_n}, 8'h00);
  endtask : hit

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(6515));
    repeat (16) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    host_model_i.rd(fault_resp_pkg::CMD_OC_ACTION, q);
    chk(q, 8'h80);
    host_model_i.rd(fault_resp_pkg::CMD_UC_ACTION, q);
    chk(q, 8'h80);
    host_model_i.rd(fault_resp_pkg::CMD_STATUS_IOUT, q);
    chk(q, 8'h00);
    chk({7'h00, alert_n}, 8'h01);
    $display("test reset done");

    for (int i = 0; i < 6; i++) begin
      g = 8'($urandom);
      host_model_i.wr(i[0] ? 8'hE6 : 8'hE5, g);
      host_model_i.rd(i[0] ? 8'hE6 : 8'hE5, q);
      chk(q, g);
    end
    host_model_i.wr(8'h55, 8'hFF);
    host_model_i.rd(8'h55, q);
    chk(q, 8'h00);
    $display("test registers done");

    // undercurrent set to retry so a latch here proves the settings split
    host_model_i.wr(fault_resp_pkg::CMD_OC_ACTION, 8'h80);
    host_model_i.wr(fault_resp_pkg::CMD_UC_ACTION, 8'hB8);
    ctrl_pin = 1'b1;
    operation_on = 1'b1;
    expect_on();
    hit(1'b1, 1'b0);
    wait_restart(40, n);
    chk(8'(n), 8'd40);
    chk({7'h00, out_en}, 8'h00);
    host_model_i.wr(fault_resp_pkg::CMD_STATUS_IOUT, 8'h00);
    host_model_i.rd(fault_resp_pkg::CMD_STATUS_IOUT, q);
    chk(q, stat(1'b1, 1'b0));
    host_model_i.clr();
    host_model_i.rd(fault_resp_pkg::CMD_STATUS_IOUT, q);
    chk(q, 8'h00);
    expect_on();
    $display("test latch done");

    for (int i = 0; i < 3; i++) begin
      d = (i == 0) ? 3'h0 : (i == 1) ? 3'h7 : 3'($urandom);
      // middle pass runs the overcurrent setting through the same walk
      host_model_i.wr((i == 1) ? fault_resp_pkg::CMD_OC_ACTION
        : fault_resp_pkg::CMD_UC_ACTION, {2'b10, 3'b111, d});
      oc_fault = (i == 1);
      uc_fault = (i != 1);
      wait_restart(400, n);
      chk({7'h00, alert_n}, 8'h00);
      wait_restart(400, n);
      chk(8'(n), gap(d));
      chk({7'h00, out_en}, 8'h01);
      oc_fault = 1'b0;
      uc_fault = 1'b0;
      if (i == 2) begin
        other_fault = 1'b1;
        @(posedge core_clk);
        #1;
        other_fault = 1'b0;
      end else begin
        operation_on = 1'b0;
      end
      wait_restart(int'(gap(d)) + 8, n);
      chk(8'(n), gap(d) + 8'd8);
      chk({7'h00, out_en}, 8'h00);
      host_model_i.rd(fault_resp_pkg::CMD_STATUS_IOUT, q);
      chk(q, stat(i == 1, i != 1));
      host_model_i.clr();
      operation_on = 1'b1;
      expect_on();
    end
    $display("test retry done");
    wrap_up();
  end
endmodule : tb
`default_nettype wire
